/* File: design/fp_unit_params.svh */
// constants for the sign-flags and square-root execution unit
`ifndef FP_UNIT_PARAMS_SVH
`define FP_UNIT_PARAMS_SVH
`define OPC_SIGN_FLAGS 8'h99
`define OPC_SQRT 8'h6e
`define OPC_SQRT_FLAGS 8'h6f
`define SLOT_CMP 3'h3
`define SLOT_LONG 3'h2
`define CMP_LATENCY 5'h01
`define SQRT_LATENCY 17
`define SQRT_RECOVERY 16
`define FLG_DBZ 0
`define FLG_INX 1
`define FLG_UNF 2
`define FLG_OVF 3
`define FLG_INV 4
`define FLG_IFZ 5
`define FLG_OFZ 6
`define FLG_W 7
`define QNAN 32'hffffffff
`define PINF 32'h7f800000
`define EXP_BIAS 9'h07f
`define OFF_ROUND 8'h00
`define OFF_FLAGS 8'h04
`define ROUND_RST 2'h0
`define FLAGS_RST 7'h00
`endif

/* File: design/fp_unit_pkg.sv */
// types shared by the execution unit and its bench
`default_nettype none
package fp_unit_pkg;
   typedef enum logic [1:0] {
      RND_NEAREST = 2'b00,
      RND_POS_INF = 2'b01,
      RND_NEG_INF = 2'b10,
      RND_ZERO = 2'b11
   } round_mode_t;
   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [2:0] slot;
      logic guard;
      logic [31:0] source_operand;
   } issue_t;
   typedef struct packed {
      logic wr;
      logic [31:0] data;
   } result_t;
   typedef struct packed {
      logic [31:0] value;
      logic [6:0] flags;
   } fp_out_t;
endpackage
`default_nettype wire

/* File: design/fp_sqrt_sign_flags_unit.sv */
// sign-flags on the compare unit, square root and square-root flags on the long-latency unit
//
// The APB slave port and the address map are this design's own decisions.
`include "fp_unit_params.svh"
`default_nettype none
// Contract
// - sign-flags: opcode 153, slot 3, latency 1
// - flag vector bits 0..6, upper bits zero
// - flags-only ops leave status flags alone
// - sign-flags: denormal flushed, input-flushed bit set
// - guard lsb 0 keeps destination unchanged
// - square root: opcode 110, slot 2, 17/16
// - square root rounds per status rounding mode
// - square root: denormal flushed, status input-flushed set
// - denormal square-root result becomes zero, output-flushed
// - square-root exceptions set sticky status flags
// - status update with destination write
// - simultaneous updates OR into flags
// - guard 0 square root: no write, no flags
// - negative operand gives all-ones NaN, invalid
// - positive infinity gives infinity, no flags
// - sqrt-flags: opcode 111, same timing, vector
// - sqrt-flags: denormal flushed, input-flushed bit
// - sign flags match sign evaluation exceptions
module fp_sqrt_sign_flags_unit #(
   parameter int SQRT_LATENCY = `SQRT_LATENCY,
   parameter int SQRT_RECOVERY = `SQRT_RECOVERY
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire fp_unit_pkg::issue_t issue_in,
   input wire logic [6:0] other_flags_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output fp_unit_pkg::result_t cmp_res_out,
   output fp_unit_pkg::result_t long_res_out,
   output logic long_busy_out,
   output logic [6:0] status_flags_out
);
   if (SQRT_LATENCY < 2 || SQRT_LATENCY > 31 || SQRT_RECOVERY < 1 || SQRT_RECOVERY >= SQRT_LATENCY) begin : chk
      $error("unsupported latency or recovery");
   end

   localparam logic [4:0] LAT_M1 = 5'(SQRT_LATENCY - 1);
   localparam logic [4:0] FREE_AT = 5'(SQRT_LATENCY - SQRT_RECOVERY + 1);

   // integer square root of a 52-bit radicand; msb of result is the sticky
   function automatic logic [26:0] isqrt(input logic [51:0] r);
      logic [27:0] rem;
      logic [27:0] t;
      logic [25:0] q;
      rem = 28'h0;
      q = 26'h0;
      for (int i = 25; i >= 0; i--) begin
         rem = {rem[25:0], r[2*i+1 -: 2]};
         t = {q, 2'b01};
         if (rem >= t) begin
            rem = rem - t;
            q = {q[24:0], 1'b1};
         end else begin
            q = {q[24:0], 1'b0};
         end
      end
      return {|rem, q};
   endfunction

   function automatic fp_unit_pkg::fp_out_t sqrt_eval(input logic [31:0] x, input fp_unit_pkg::round_mode_t rm);
      fp_unit_pkg::fp_out_t o;
      logic [7:0] e;
      logic [51:0] rad;
      logic [26:0] sq;
      logic [23:0] mant;
      logic [24:0] mr;
      logic [7:0] re;
      logic g;
      logic st;
      logic up;
      o = '0;
      e = x[30:23];
      rad = '0;
      sq = '0;
      mant = '0;
      mr = '0;
      re = '0;
      g = 1'b0;
      st = 1'b0;
      up = 1'b0;
      if (e == 8'hff && x[22:0] != 23'h0) begin
         o.value = `QNAN;
         o.flags[`FLG_INV] = ~x[22];
      end else if (e == 8'h00) begin
         o.value = {x[31], 31'h0};
         o.flags[`FLG_IFZ] = (x[22:0] != 23'h0);
      end else if (x[31]) begin
         o.value = `QNAN;
         o.flags[`FLG_INV] = 1'b1;
      end else if (e == 8'hff) begin
         o.value = `PINF;
      end else begin
         // odd biased exponent means an even true exponent, so no pre-shift
         rad = e[0] ? {1'b0, 1'b1, x[22:0], 27'h0} : {1'b1, x[22:0], 28'h0};
         sq = isqrt(rad);
         mant = sq[25:2];
         g = sq[1];
         st = sq[0] | sq[26];
         case (rm)
            fp_unit_pkg::RND_NEAREST: up = g & (st | mant[0]);
            fp_unit_pkg::RND_POS_INF: up = g | st;
            default: up = 1'b0;
         endcase
         mr = {1'b0, mant} + {24'h0, up};
         re = 8'(({1'b0, e} + `EXP_BIAS) >> 1);
         o.flags[`FLG_INX] = g | st;
         if (re == 8'h00) begin
            // only a wider exponent range could reach this; kept for safety
            o.value = 32'h0;
            o.flags[`FLG_OFZ] = 1'b1;
         end else begin
            o.value = {1'b0, 8'(re + {7'h0, mr[24]}), mr[22:0]};
         end
      end
      return o;
   endfunction

   function automatic logic [6:0] sign_flags(input logic [31:0] x);
      logic [6:0] f;
      f = '0;
      if (x[30:23] == 8'h00 && x[22:0] != 23'h0) begin
         f[`FLG_IFZ] = 1'b1;
      end
      // ordering a NaN against zero is an invalid comparison
      if (x[30:23] == 8'hff && x[22:0] != 23'h0) begin
         f[`FLG_INV] = 1'b1;
      end
      return f;
   endfunction

   fp_unit_pkg::round_mode_t round_q;
   logic [6:0] flags_q;
   logic [6:0] flags_d;
   logic [4:0] cnt_q;
   logic busy_q;
   fp_unit_pkg::fp_out_t pend_q;
   logic pend_fo_q;
   logic pend_guard_q;
   fp_unit_pkg::result_t cmp_q;
   fp_unit_pkg::result_t long_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic sign_go;
   logic long_go;
   logic done;
   logic done_upd;
   logic apb_wr;
   logic bad_addr;

   assign sign_go = issue_in.valid && issue_in.opcode == `OPC_SIGN_FLAGS && issue_in.slot == `SLOT_CMP;
   // an issue during recovery is dropped; the issuer must respect busy
   assign long_go = issue_in.valid && issue_in.slot == `SLOT_LONG && !busy_q
                    && (issue_in.opcode == `OPC_SQRT || issue_in.opcode == `OPC_SQRT_FLAGS);
   assign done = cnt_q == 5'h01;
   assign done_upd = done && pend_guard_q && !pend_fo_q;
   assign apb_wr = psel_in && penable_in && pready_q && pwrite_in;
   assign bad_addr = paddr_in != `OFF_ROUND && paddr_in != `OFF_FLAGS;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cmp_q <= '0;
      end else begin
         cmp_q.wr <= sign_go && issue_in.guard;
         if (sign_go && issue_in.guard) begin
            cmp_q.data <= {25'h0, sign_flags(issue_in.source_operand)};
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cnt_q <= 5'h0;
         busy_q <= 1'b0;
         pend_q <= '0;
         pend_fo_q <= 1'b0;
         pend_guard_q <= 1'b0;
      end else begin
         if (long_go) begin
            cnt_q <= LAT_M1;
            busy_q <= 1'b1;
            pend_q <= sqrt_eval(issue_in.source_operand, round_q);
            pend_fo_q <= issue_in.opcode == `OPC_SQRT_FLAGS;
            pend_guard_q <= issue_in.guard;
         end else begin
            if (cnt_q != 5'h0) begin
               cnt_q <= cnt_q - 5'h01;
            end
            if (cnt_q == FREE_AT) begin
               busy_q <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         long_q <= '0;
      end else begin
         long_q.wr <= done && pend_guard_q;
         if (done && pend_guard_q) begin
            long_q.data <= pend_fo_q ? {25'h0, pend_q.flags} : pend_q.value;
         end
      end
   end

   // hardware sets win over a software write in the same cycle
   always_comb begin
      flags_d = apb_wr && paddr_in == `OFF_FLAGS ? pwdata_in[6:0] : flags_q;
      flags_d = flags_d | other_flags_in;
      if (done_upd) begin
         flags_d = flags_d | pend_q.flags;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         flags_q <= `FLAGS_RST;
         round_q <= fp_unit_pkg::round_mode_t'(`ROUND_RST);
      end else begin
         flags_q <= flags_d;
         if (apb_wr && paddr_in == `OFF_ROUND) begin
            round_q <= fp_unit_pkg::round_mode_t'(pwdata_in[1:0]);
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= psel_in && !penable_in;
         pslverr_q <= psel_in && !penable_in && bad_addr;
         if (psel_in && !penable_in) begin
            if (paddr_in == `OFF_ROUND) begin
               prdata_q <= {30'h0, round_q};
            end else if (paddr_in == `OFF_FLAGS) begin
               prdata_q <= {25'h0, flags_q};
            end else begin
               prdata_q <= 32'h0;
            end
         end
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign cmp_res_out = cmp_q;
   assign long_res_out = long_q;
   assign long_busy_out = busy_q;
   assign status_flags_out = flags_q;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence long_issue_s;
      long_go && issue_in.guard;
   endsequence
   sequence recover_s;
      busy_q [*8] ##1 busy_q [*7] ##1 !busy_q;
   endsequence

   sign_latency_a: assert property (sign_go && issue_in.guard |=> cmp_res_out.wr)
      else $error("sign flags not written one cycle after issue");
   flag_width_a: assert property (cmp_res_out.wr |-> cmp_res_out.data[31:7] == 25'h0)
      else $error("flag vector upper bits set");
   flagsonly_quiet_a: assert property (done && pend_fo_q && !apb_wr && other_flags_in == 7'h0
      |=> flags_q == $past(flags_q))
      else $error("flags-only op changed status flags");
   sign_ifz_a: assert property (sign_go && issue_in.guard && issue_in.source_operand[30:23] == 8'h00
      && issue_in.source_operand[22:0] != 23'h0 |=> cmp_res_out.data[5])
      else $error("input-flushed bit missing");
   guard_hold_a: assert property (sign_go && !issue_in.guard && !long_q.wr |=> !cmp_res_out.wr)
      else $error("destination written with false guard");
   sqrt_latency_a: assert property (long_issue_s |-> ##17 long_res_out.wr)
      else $error("long result not at latency 17");
   recovery_a: assert property (long_go |=> recover_s)
      else $error("recovery window wrong");
   sticky_a: assert property (!apb_wr |=> (flags_q & $past(flags_q)) == $past(flags_q))
      else $error("sticky flag cleared without write");
   same_cycle_a: assert property (done_upd |=> long_res_out.wr
      && (flags_q & $past(pend_q.flags)) == $past(pend_q.flags))
      else $error("flag update not with destination write");
   neg_nan_a: assert property ((long_issue_s and (issue_in.opcode == `OPC_SQRT && issue_in.source_operand[31]
      && issue_in.source_operand[30:23] != 8'h00)) |-> ##17 long_res_out.data == `QNAN)
      else $error("negative operand not NaN");
   guard_flags_a: assert property (done && !pend_guard_q && !apb_wr && other_flags_in == 7'h0
      |=> flags_q == $past(flags_q) && !long_res_out.wr)
      else $error("false guard touched flags or destination");
endmodule
`default_nettype wire

/* File: tb/fp_issue_model.sv */
// issue-side model: launches one operation at a time into the unit
`include "fp_unit_params.svh"
`default_nettype none
module fp_issue_model (
   input wire logic clk_in,
   input wire logic busy_in,
   output fp_unit_pkg::issue_t issue_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial issue_out = '0;
   task automatic send(input logic [7:0] op, input logic g, input logic [31:0] src);
      logic [2:0] sl;
      sl = (op == `OPC_SIGN_FLAGS) ? `SLOT_CMP : `SLOT_LONG;
      // busy is read mid-cycle, where it has settled; it only falls without a new issue
      @(negedge clk_in);
      // never reissue into a recovering long unit
      while (busy_in) begin
         @(negedge clk_in);
      end
      @(posedge clk_in);
      issue_out <= '{1'h1, op, sl, g, src};
      @(posedge clk_in);
      issue_out <= '0;
   endtask
endmodule
`default_nettype wire

/* File: tb/fp_sqrt_sign_flags_unit_bench.sv */
// self-checking bench for the sign-flags and square-root unit
`include "fp_unit_params.svh"
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; $display("Error %0t got %h exp %h", $time, a, e); end end
module fp_sqrt_sign_flags_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, busy, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [6:0] oflags, sflags;
   fp_unit_pkg::issue_t iss;
   fp_unit_pkg::result_t cres, lres;
   int n_fail = 0, compares = 0, cyc = 0, n, nb;
   fp_sqrt_sign_flags_unit i_fp_sqrt_sign_flags_unit (.core_clk_in(clk), .rst_in(rst), .issue_in(iss),
      .other_flags_in(oflags), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .cmp_res_out(cres), .long_res_out(lres), .long_busy_out(busy), .status_flags_out(sflags));
   fp_issue_model i_fp_issue_model (.clk_in(clk), .busy_in(busy), .issue_out(iss));
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task tally_and_finish();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      // at the edge the answer still shows its pre-edge value, which is what the slave presents
      @(posedge clk);
      while (pready !== 1'h1) begin
         @(posedge clk);
      end
      d = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // let a write land before the caller looks at the flags
      #1;
   endtask
   task run(input logic [7:0] op, input logic g, input logic [31:0] src);
      i_fp_issue_model.send(op, g, src);
      // send returns on the edge that takes the issue; latency 1 shows just after it
      n = 1;
      #1;
      nb = busy;
      while (!(cres.wr | lres.wr) && n < 40) begin
         @(posedge clk);
         #1;
         n++;
         nb += busy;
      end
      d = (op == `OPC_SIGN_FLAGS) ? cres.data : lres.data;
   endtask
   task t_regs();
      `CHK(sflags, 7'h00)
      apb(1'h0, `OFF_ROUND, 32'h0);
      `CHK(d, 32'h0)
      apb(1'h0, 8'h08, 32'h0);
      `CHK(err, 1'h1)
   endtask
   task automatic t_sign();
      logic [31:0] s [4] = '{32'h40400000, 32'hff800000, 32'h80400000, 32'hffffffff};
      logic [31:0] ev [4] = '{32'h0, 32'h0, 32'h20, 32'h10};
      for (int i = 0; i < 4; i++) begin
         run(`OPC_SIGN_FLAGS, 1'h1, s[i]);
         `CHK(n, 1)
         `CHK(d, ev[i])
         `CHK(sflags, 7'h00)
      end
      run(`OPC_SIGN_FLAGS, 1'h0, 32'h80400000);
      `CHK(n, 40)
      `CHK(d, 32'h10)
   endtask
   task t_sqrt();
      run(`OPC_SQRT, 1'h1, 32'h40400000);
      `CHK(n, `SQRT_LATENCY)
      `CHK(nb, `SQRT_RECOVERY - 1)
      `CHK(d, 32'h3fddb3d7)
      `CHK(sflags, 7'h02)
      run(`OPC_SQRT, 1'h1, 32'hc0400000);
      `CHK(d, `QNAN)
      `CHK(sflags, 7'h12)
      run(`OPC_SQRT, 1'h1, `PINF);
      `CHK(d, `PINF)
      `CHK(sflags, 7'h12)
      run(`OPC_SQRT, 1'h1, 32'h00400000);
      `CHK(d, 32'h0)
      `CHK(sflags, 7'h32)
      apb(1'h1, `OFF_FLAGS, 32'h0);
      `CHK(sflags, 7'h00)
      run(`OPC_SQRT, 1'h0, 32'hc0400000);
      `CHK(n, 40)
      `CHK(d, 32'h0)
      `CHK(sflags, 7'h00)
   endtask
   task automatic t_sqflags();
      logic [31:0] s [4] = '{32'h40400000, 32'h00400000, 32'hc0400000, `PINF};
      logic [31:0] ev [4] = '{32'h2, 32'h20, 32'h10, 32'h0};
      for (int i = 0; i < 4; i++) begin
         run(`OPC_SQRT_FLAGS, 1'h1, s[i]);
         `CHK(n, `SQRT_LATENCY)
         `CHK(d, ev[i])
         `CHK(sflags, 7'h00)
      end
   endtask
   task t_round();
      apb(1'h1, `OFF_ROUND, 32'h3);
      run(`OPC_SQRT, 1'h1, 32'h40400000);
      `CHK(d, 32'h3fddb3d7)
      apb(1'h1, `OFF_ROUND, 32'h1);
      apb(1'h0, `OFF_ROUND, 32'h0);
      `CHK(d, 32'h1)
      run(`OPC_SQRT, 1'h1, 32'h40400000);
      `CHK(d, 32'h3fddb3d8)
   endtask
   task t_or();
      apb(1'h1, `OFF_FLAGS, 32'h0);
      @(posedge clk);
      oflags <= 7'h09;
      @(posedge clk);
      oflags <= 7'h40;
      #1;
      `CHK(sflags, 7'h09)
      @(posedge clk);
      oflags <= 7'h00;
      #1;
      `CHK(sflags, 7'h49)
   endtask
   initial begin
      rst = 1'h1;
      oflags = 7'h00;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      t_regs();
      t_sign();
      t_sqrt();
      t_sqflags();
      t_round();
      t_or();
      tally_and_finish();
   end
endmodule
`default_nettype wire
